// ==== rtl/fbrc_burst_read.v ====
// Synchronous burst read sequencer with its read configuration register.
// Assumes an array source on CLK_I that answers MEM_ADDR_O with
// valid/ready, and a host that drives the burst clock and strobes.
//
// Function
// R1: Wrap bit 3 low confines burst to its 4/8 group; high runs past.
// R2: One address latch starts a burst of 4, 8 or continuous words.
// R3: Host sets sequential order whenever continuous length is chosen.
// R4: Continuous bursts keep incrementing addresses across bank borders.
// R5: Linear burst starting 4-word aligned inserts no wait at all.
// R6: Offset 1..3 inserts that many wait cycles at first 64 crossing.
// R7: Boundary wait happens at most once per burst.
// R8: Reserved bits 14, 5, 4 carry no function.
// R9: Bit 15 selects sync (0) or async (1) reads; resets to async.
// R10: Latency code 2..5 sets cycles to first data; others reserved.
// R11: Bit 10 makes wait active low (0) or active high (1).
// R12: Bit 9 holds each data word one (0) or two (1) clocks.
// R13: Bit 8 asserts wait during (0) or one cycle before (1) wait; with 1 the code warns during the next-to-last good word.
// R14: Bit 7 picks interleaved (0) or sequential (1) order.
// R15: Bit 6 picks falling (0) or rising (1) active burst clock edge.
// R16: Wrap order: sequential modulo group, interleaved start XOR beat.
// R17: No-wrap fixed bursts run linear; wrap ignored for continuous.
// R18: Host writes a legal latency and length before synchronous reads.
`timescale 1ns/10ps
`include "fbrc_defines.vh"

module fbrc_burst_read #(
  parameter AW = 21,
  parameter DW = 16
) (
  // Clock and reset.
  input  wire          CLK_I,
  input  wire          RESET_I,
  // Read configuration register port.
  input  wire          CFG_WE_I,
  input  wire [15:0]   CFG_WDATA_I,
  output wire [15:0]   CFG_RDATA_O,
  // Host-side pins.
  input  wire          BCLK_I,
  input  wire          LATCH_N_I,
  input  wire          CHIP_EN_N_I,
  input  wire [AW-1:0] ADDR_I,
  output reg  [DW-1:0] DQ_O,
  output reg           DQ_OE_O,
  output reg           WAIT_O,
  // Array read stream.
  output wire [AW-1:0] MEM_ADDR_O,
  output wire          MEM_RD_O,
  input  wire [DW-1:0] MEM_DATA_I,
  input  wire          MEM_VALID_I,
  output wire          MEM_READY_O
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_LAT   = 5'h02;
  localparam [4:0] ST_DATA  = 5'h04;
  localparam [4:0] ST_BWAIT = 5'h08;
  localparam [4:0] ST_DONE  = 5'h10;

  // Group sizes at address width, so length compares match in size.
  localparam [AW-1:0] GROUP_4_W = `FBRC_GROUP_4;
  localparam [AW-1:0] GROUP_8_W = `FBRC_GROUP_8;

  reg  [15:0]   cfg_q;
  reg  [2:0]    bclk_q;
  reg  [1:0]    latch_n_q;
  reg  [1:0]    chip_n_q;
  reg  [AW-1:0] addr_s1_q;
  reg  [AW-1:0] addr_s2_q;
  reg           armed_q;
  reg  [4:0]    st_q;
  reg  [AW-1:0] start_q;
  reg  [AW-1:0] beat_q;
  reg  [AW-1:0] push_q;
  reg  [2:0]    lat_q;
  reg  [1:0]    bw_q;
  reg           bw_done_q;
  reg           hold_q;
  reg           stall_q;
  reg           act_q;
  reg  [DW-1:0] buf_q [0:1];
  reg           wr_q;
  reg           rd_q;
  reg  [1:0]    cnt_q;

  // Register fields.
  wire          sync_mode = ~cfg_q[`FBRC_READ_MODE_BIT];        // [R9]
  wire [2:0]    lat_code  = cfg_q[`FBRC_LAT_MSB:`FBRC_LAT_LSB];
  wire          pol_high  = cfg_q[`FBRC_HOLD_POL_BIT];
  wire          hold_two  = cfg_q[`FBRC_DATA_HOLD_BIT];
  wire          early     = cfg_q[`FBRC_HOLD_TIME_BIT];
  wire          seq_order = cfg_q[`FBRC_ORDER_BIT];
  wire          rise_edge = cfg_q[`FBRC_EDGE_BIT];
  wire          no_wrap   = cfg_q[`FBRC_WRAP_BIT];
  wire [2:0]    len_code  = cfg_q[`FBRC_LEN_MSB:`FBRC_LEN_LSB];
  wire          len4      = (len_code == `FBRC_LEN_4);
  wire          len8      = (len_code == `FBRC_LEN_8);
  wire          fixed     = len4 | len8;                         // [R2]
  wire [AW-1:0] len_words = len8 ? GROUP_8_W : GROUP_4_W;
  // Wrap only matters for fixed lengths; continuous is always linear.
  wire          linear    = ~fixed | no_wrap;                    // [R17]

  // Reserved bits read back as zero and are never decoded.
  assign CFG_RDATA_O = cfg_q & `FBRC_CFG_MASK;                   // [R8]

  // Address of beat i; interleave only applies inside a wrapped group.
  // Every input is an argument, so each caller updates on all of them.
  function [AW-1:0] addr_of;
    input [AW-1:0] s;
    input [AW-1:0] i;
    input          seq;
    input          lin;
    input          l8;
    reg   [2:0]    off;
    begin
      off = seq ? (s[2:0] + i[2:0])                              // [R14]
                : (s[2:0] ^ i[2:0]);                             // [R16]
      if (lin) begin
        addr_of = s + i;                                         // [R4]
      end else if (l8) begin
        addr_of = {s[AW-1:3], off};                              // [R1]
      end else begin
        addr_of = {s[AW-1:2], off[1:0]};                         // [R1]
      end
    end
  endfunction

  // Active edge of the sampled burst clock; bclk_q[0] feeds only bit 1.
  wire tick = rise_edge ? (bclk_q[1] & ~bclk_q[2])               // [R15]
                        : (~bclk_q[1] & bclk_q[2]);
  wire sel  = ~chip_n_q[1];
  wire start_ev = tick & sync_mode & sel & ~latch_n_q[1] & armed_q;

  // A word is due now: latency elapsed, hold elapsed, or wait over.
  wire due = tick & (((st_q == ST_LAT) & (lat_q == 3'h1)) |
                     ((st_q == ST_DATA) & ~hold_q) |
                     ((st_q == ST_BWAIT) & (bw_q == 2'h1)));
  wire at_end  = fixed & (beat_q == len_words);
  // One-shot wait when a misaligned linear burst reaches the boundary.
  wire [AW-1:0] beat_addr = addr_of(start_q, beat_q, seq_order, linear,
                                    len8);
  wire need_bw = linear & (start_q[1:0] != 2'h0) & ~bw_done_q &  // [R5]
                 (beat_q != {AW{1'b0}}) &                        // [R7]
                 (beat_addr[`FBRC_BOUNDARY_BITS-1:0] == 6'h00);  // [R6]
  wire pop     = due & ~at_end & ~need_bw & (cnt_q != 2'h0);
  // Predicts whether the word after this one will be a wait.
  wire [AW-1:0] nxt = beat_q + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] nxt_addr = addr_of(start_q, nxt, seq_order, linear, len8);
  wire pred_wait = (fixed & (nxt == len_words)) |
                   (linear & (start_q[1:0] != 2'h0) & ~bw_done_q &
                    (nxt_addr[`FBRC_BOUNDARY_BITS-1:0] == 6'h00));
  wire push    = MEM_VALID_I & MEM_READY_O;

  assign MEM_READY_O = act_q & (cnt_q != 2'h2);
  assign MEM_RD_O    = act_q & (~fixed | (push_q < len_words));
  assign MEM_ADDR_O  = addr_of(start_q, push_q, seq_order, linear, len8);

  // Configuration register; only the command side may write it.
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      cfg_q <= `FBRC_CFG_RESET;                                  // [R9]
    end else if (CFG_WE_I) begin
      cfg_q <= CFG_WDATA_I & `FBRC_CFG_MASK;
    end
  end

  // Two-flop synchronisers for all host pins, plus one edge stage.
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      bclk_q    <= 3'h0;
      latch_n_q <= 2'h3;
      chip_n_q  <= 2'h3;
      addr_s1_q <= {AW{1'b0}};
      addr_s2_q <= {AW{1'b0}};
    end else begin
      bclk_q    <= {bclk_q[1:0], BCLK_I};
      latch_n_q <= {latch_n_q[0], LATCH_N_I};
      chip_n_q  <= {chip_n_q[0], CHIP_EN_N_I};
      addr_s1_q <= ADDR_I;
      addr_s2_q <= addr_s1_q;
    end
  end

  // Two-entry buffer; a flush at burst start drops stale prefetch.
  always @(posedge CLK_I) begin
    if (RESET_I | start_ev) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      cnt_q  <= 2'h0;
      push_q <= {AW{1'b0}};
    end else begin
      if (push) begin
        buf_q[wr_q] <= MEM_DATA_I;
        wr_q        <= ~wr_q;
        push_q      <= push_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Burst sequencer, stepped on active edges of the burst clock.
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      st_q      <= ST_IDLE;
      armed_q   <= 1'b0;
      start_q   <= {AW{1'b0}};
      beat_q    <= {AW{1'b0}};
      lat_q     <= 3'h0;
      bw_q      <= 2'h0;
      bw_done_q <= 1'b0;
      hold_q    <= 1'b0;
      stall_q   <= 1'b0;
      act_q     <= 1'b0;
      DQ_O      <= {DW{1'b0}};
    end else begin
      // Rearm only once a strobe has gone high again.
      if (latch_n_q[1] | ~sel) begin
        armed_q <= 1'b1;
      end else if (start_ev) begin
        armed_q <= 1'b0;
      end
      if (~sel | ~sync_mode) begin
        st_q  <= ST_IDLE;
        act_q <= 1'b0;
      end else if (start_ev) begin
        st_q      <= ST_LAT;                                     // [R2]
        start_q   <= addr_s2_q;
        beat_q    <= {AW{1'b0}};
        // Reserved latency codes fall back to the longest legal one.
        lat_q     <= ((lat_code >= `FBRC_LAT_MIN) &&
                      (lat_code <= `FBRC_LAT_MAX)) ?
                     lat_code : `FBRC_LAT_MAX;                   // [R10]
        bw_done_q <= 1'b0;
        hold_q    <= 1'b0;
        stall_q   <= 1'b0;
        act_q     <= 1'b1;
      end else if (tick) begin
        case (st_q)
          ST_LAT: begin
            lat_q <= lat_q - 3'h1;                               // [R10]
          end
          ST_DATA: begin
            hold_q <= 1'b0;                                      // [R12]
          end
          ST_BWAIT: begin
            bw_q <= bw_q - 2'h1;                                 // [R6]
          end
          default: begin
          end
        endcase
        if (due) begin
          stall_q <= 1'b0;
          if (at_end) begin
            st_q <= ST_DONE;
          end else if (need_bw) begin
            st_q      <= ST_BWAIT;
            bw_q      <= start_q[1:0];                           // [R6]
            bw_done_q <= 1'b1;                                   // [R7]
          end else if (cnt_q == 2'h0) begin
            st_q    <= ST_DATA;
            stall_q <= 1'b1;
          end else begin
            st_q   <= ST_DATA;
            DQ_O   <= buf_q[rd_q];
            beat_q <= nxt;
            hold_q <= hold_two;                                  // [R12]
          end
        end
      end
    end
  end

  // Wait is raised whenever the word on the bus is not valid; the early
  // option warns during the next-to-last good word before a wait state.
  wire wait_now  = ~sync_mode | ~sel | (st_q != ST_DATA) | stall_q;
  // Polarity follows a write at once, so a new setting never shows a
  // false ready for one cycle while the data pins are off.
  wire pol_next  = CFG_WE_I ? CFG_WDATA_I[`FBRC_HOLD_POL_BIT] : pol_high;
  wire wait_soon = early & (st_q == ST_DATA) & ~stall_q &        // [R13]
                   (hold_q ? 1'b0 : pred_wait) & ~hold_two;
  wire wait_two  = early & (st_q == ST_DATA) & ~stall_q &        // [R13]
                   ~hold_q & hold_two & pred_wait;
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      WAIT_O  <= 1'b1;
      DQ_OE_O <= 1'b0;
    end else begin
      WAIT_O  <= pol_next ? (wait_now | wait_soon | wait_two)   // [R11]
                          : ~(wait_now | wait_soon | wait_two);
      DQ_OE_O <= sel & sync_mode;
    end
  end

endmodule // fbrc_burst_read

// ==== rtl/fbrc_defines.vh ====
// Constants for the burst read configuration and sequencing block.
// Assumes it is included by bare name from the design file only.
`ifndef FBRC_DEFINES_VH
`define FBRC_DEFINES_VH

// Read configuration register reset value and writable-bit mask.
`define FBRC_CFG_RESET      16'hbfcf
`define FBRC_CFG_MASK       16'hbfcf

// Field positions inside the read configuration register.
`define FBRC_READ_MODE_BIT  15
`define FBRC_LAT_MSB        13
`define FBRC_LAT_LSB        11
`define FBRC_HOLD_POL_BIT   10
`define FBRC_DATA_HOLD_BIT  9
`define FBRC_HOLD_TIME_BIT  8
`define FBRC_ORDER_BIT      7
`define FBRC_EDGE_BIT       6
`define FBRC_WRAP_BIT       3
`define FBRC_LEN_MSB        2
`define FBRC_LEN_LSB        0

// Burst length codes.
`define FBRC_LEN_4          3'h1
`define FBRC_LEN_8          3'h2
`define FBRC_LEN_CONT       3'h7

// Latency codes: legal codes equal their cycle count.
`define FBRC_LAT_MIN        3'h2
`define FBRC_LAT_MAX        3'h5

// Word group sizes and the boundary that costs extra cycles.
`define FBRC_GROUP_4        4
`define FBRC_GROUP_8        8
`define FBRC_BOUNDARY_BITS  6

`endif

// ==== tb/fbrc_array_model.sv ====
// Array source model answering the sequencer's word requests.
// Assumes the MEM_* valid/ready stream; slow_i gives one word in three.
`timescale 1ns/10ps
module fbrc_array_model (
  // Stream from the sequencer.
  input  wire        clk_i,
  input  wire        rd_i,
  input  wire [20:0] addr_i,
  input  wire        ready_i,
  input  wire        slow_i,
  // Stream back to the sequencer.
  output reg  [15:0] data_o,
  output reg         valid_o
);
  reg [1:0] cnt_q = 2'h0;
  // Data scrambles the address; an idle bus shows its inverse, not junk.
  always @* begin
    valid_o = rd_i && (!slow_i || cnt_q == 2'h0);
    data_o  = (addr_i[15:0] ^ 16'h5a5a) ^ {16{!valid_o}};
  end
  // A word once offered stays offered until it is taken.
  always @(posedge clk_i) begin
    if (!valid_o || ready_i) begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
    end
  end
endmodule // fbrc_array_model

// ==== tb/fbrc_burst_read_checker.sv ====
// Port checker for the burst read sequencer.
// Assumes it is bound to fbrc_burst_read; the burst clock is seen raw.
`timescale 1ns/10ps
module fbrc_burst_read_checker #(
  parameter AW = 21,
  parameter DW = 16
) (
  // Every port of the sequencer; ADDR_I, MEM_DATA_I and MEM_VALID_I are not checked.
  input wire          CLK_I, RESET_I, CFG_WE_I, BCLK_I,
  input wire          LATCH_N_I, CHIP_EN_N_I, DQ_OE_O, WAIT_O,
  input wire          MEM_RD_O, MEM_VALID_I, MEM_READY_O,
  input wire [15:0]   CFG_WDATA_I, CFG_RDATA_O,
  input wire [AW-1:0] ADDR_I, MEM_ADDR_O,
  input wire [DW-1:0] DQ_O, MEM_DATA_I
);
  reg  [2:0] bsync_q, strobes_q;
  reg  [3:0] since_q, quiet_q;
  wire       act = CFG_RDATA_O[6] ? (bsync_q[1] & ~bsync_q[2])
                                  : (~bsync_q[1] & bsync_q[2]);
  // Ages since an active edge and since any strobe moved, saturating.
  always @(posedge CLK_I) begin
    bsync_q   <= {bsync_q[1:0], BCLK_I};
    strobes_q <= {CHIP_EN_N_I, LATCH_N_I, CFG_WE_I};
    if (RESET_I) begin
      since_q <= 4'hf;
    end else begin
      since_q <= act ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
    end
    if (RESET_I || strobes_q != {CHIP_EN_N_I, LATCH_N_I, CFG_WE_I}) begin
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence async_held;
    (CFG_RDATA_O[15] && $stable(CFG_RDATA_O)) [*3];
  endsequence
  sequence chip_off;
    (CHIP_EN_N_I && $stable(CFG_RDATA_O)) [*6];
  endsequence
  chk_reset_value: assert property (disable iff (1'b0)
    RESET_I |=> CFG_RDATA_O == 16'hbfcf) else $error("bad reset value");
  chk_write_mask: assert property (CFG_WE_I |=>
    CFG_RDATA_O == ($past(CFG_WDATA_I) & 16'hbfcf)) else $error("bad cfg");
  chk_async_idle: assert property (async_held |->
    WAIT_O == CFG_RDATA_O[10] && !DQ_OE_O) else $error("async not idle");
  chk_chip_off: assert property (chip_off |->
    WAIT_O == CFG_RDATA_O[10] && !DQ_OE_O) else $error("off not idle");
  chk_data_tick: assert property ($changed(DQ_O) && quiet_q > 4'ha
    |-> since_q <= 4'h6) else $error("data moved off tick");
  chk_wait_tick: assert property ($changed(WAIT_O) && quiet_q > 4'ha
    |-> since_q <= 4'h6) else $error("wait moved off tick");
  chk_valid_drives: assert property (!CFG_RDATA_O[15] &&
    WAIT_O != CFG_RDATA_O[10] |-> DQ_OE_O) else $error("data not driven");
  chk_addr_hold: assert property (MEM_RD_O && !MEM_READY_O &&
    since_q > 4'h6 |=> $stable(MEM_ADDR_O)) else $error("addr moved");
endmodule // fbrc_burst_read_checker
bind fbrc_burst_read fbrc_burst_read_checker #(.AW(AW), .DW(DW)) u_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CFG_WE_I(CFG_WE_I), .BCLK_I(BCLK_I),
  .LATCH_N_I(LATCH_N_I), .CHIP_EN_N_I(CHIP_EN_N_I), .DQ_OE_O(DQ_OE_O),
  .WAIT_O(WAIT_O), .MEM_RD_O(MEM_RD_O), .MEM_VALID_I(MEM_VALID_I),
  .MEM_READY_O(MEM_READY_O), .CFG_WDATA_I(CFG_WDATA_I),
  .CFG_RDATA_O(CFG_RDATA_O), .ADDR_I(ADDR_I), .MEM_ADDR_O(MEM_ADDR_O),
  .DQ_O(DQ_O), .MEM_DATA_I(MEM_DATA_I));

// ==== tb/testbench.sv ====
// Self-checking bench for the burst read sequencer.
// Assumes the checker binds itself and the array model feeds MEM_*.
`timescale 1ns/10ps
module testbench;
  reg         CLK_I = 1'b0, RESET_I = 1'b1, CFG_WE_I = 1'b0, slow = 1'b0;
  reg         BCLK_I = 1'b0, LATCH_N_I = 1'b1, CHIP_EN_N_I = 1'b1;
  reg  [15:0] CFG_WDATA_I = 16'h0;
  reg  [20:0] ADDR_I = 21'h0;
  reg         bclk_run = 1'b0;
  wire [15:0] CFG_RDATA_O, DQ_O, MEM_DATA_I;
  wire [20:0] MEM_ADDR_O;
  wire        DQ_OE_O, WAIT_O, MEM_RD_O, MEM_VALID_I, MEM_READY_O;
  integer     num_errors = 0, samples_checked = 0;
  fbrc_burst_read DUT (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .CFG_WE_I(CFG_WE_I), .CFG_WDATA_I(CFG_WDATA_I),
    .CFG_RDATA_O(CFG_RDATA_O), .BCLK_I(BCLK_I), .LATCH_N_I(LATCH_N_I),
    .CHIP_EN_N_I(CHIP_EN_N_I), .ADDR_I(ADDR_I), .DQ_O(DQ_O),
    .DQ_OE_O(DQ_OE_O), .WAIT_O(WAIT_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_RD_O(MEM_RD_O), .MEM_DATA_I(MEM_DATA_I),
    .MEM_VALID_I(MEM_VALID_I), .MEM_READY_O(MEM_READY_O));
  fbrc_array_model u_array (.clk_i(CLK_I), .rd_i(MEM_RD_O),
    .addr_i(MEM_ADDR_O), .ready_i(MEM_READY_O), .slow_i(slow),
    .data_o(MEM_DATA_I), .valid_o(MEM_VALID_I));
  // System clock, and a burst clock that rests low between bursts.
  initial forever #2.5 CLK_I = ~CLK_I;
  initial begin
    #1;
    forever begin
      #24;
      if (bclk_run || BCLK_I) BCLK_I = ~BCLK_I;
    end
  end
  // Word expected at beat i, from the order and containment settings.
  function [15:0] exp_word(input [15:0] c, input [20:0] s, input [20:0] i);
    reg [20:0] g, a;
    begin
      g = (c[2:0] == 3'h1) ? 21'h4 : (c[2:0] == 3'h2) ? 21'h8 : 21'h0;
      if (c[3] || g == 21'h0) a = s + i;
      else if (c[7]) a = (s & ~(g - 21'h1)) | ((s + i) & (g - 21'h1));
      else a = s ^ i;
      exp_word = a[15:0] ^ 16'h5a5a;
    end
  endfunction
  task check(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cfg_write(input [15:0] d);
    begin
      @(posedge CLK_I);
      CFG_WE_I    <= 1'b1;
      CFG_WDATA_I <= d;
      @(posedge CLK_I);
      CFG_WE_I    <= 1'b0;
      @(posedge CLK_I);
    end
  endtask
  // One burst; words are read at active edges where wait is off.
  task burst(input [15:0] c, input [20:0] a, input integer n, input integer w);
    integer lead, mid, got, k;
    begin
      lead = 0; mid = 0; got = 0; k = 0;
      cfg_write(c);
      ADDR_I      <= a;
      LATCH_N_I   <= 1'b0;
      CHIP_EN_N_I <= 1'b0;
      repeat (6) @(posedge CLK_I);
      bclk_run <= 1'b1;
      do @(BCLK_I); while (BCLK_I !== c[6]);
      @(posedge CLK_I);
      LATCH_N_I <= 1'b1;
      while (got < n * (c[9] + 1) && k < 300) begin
        do @(BCLK_I); while (BCLK_I !== c[6]);
        k = k + 1;
        if (WAIT_O === ~c[10]) begin
          check("word", exp_word(c, a, got / (c[9] + 1)), DQ_O);
          got = got + 1;
        end else if (got == 0) lead = lead + 1;
        else mid = mid + 1;
      end
      check("words", n * (c[9] + 1), got);
      check("latency", c[13:11], lead);
      check("waits", w, mid);
      if (c[2:0] != 3'h7) begin
        do @(BCLK_I); while (BCLK_I !== c[6]);
        check("end wait", c[10], WAIT_O);
      end
      bclk_run = 1'b0;
      @(posedge CLK_I);
      CHIP_EN_N_I <= 1'b1;
      repeat (30) @(posedge CLK_I);
    end
  endtask
  task wrap_up;
    begin
      $display("mismatches %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  // Main sequence: reset values, masking, then one burst per mode.
  initial begin
    repeat (20) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    #1;
    check("cfg", 16'hbfcf, CFG_RDATA_O);
    check("idle wait", 1'b1, WAIT_O);
    cfg_write(16'hffff);
    #1;
    check("cfg", 16'hbfcf, CFG_RDATA_O);
    burst(16'h14c1, 21'h1, 4, 0);
    burst(16'h1442, 21'h3, 8, 0);
    burst(16'h14c9, 21'h3e, 4, 2);
    // A reset in mid-run must bring back asynchronous reads.
    RESET_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    #1;
    check("cfg", 16'hbfcf, CFG_RDATA_O);
    check("idle wait", 1'b1, WAIT_O);
    slow <= 1'b1;
    burst(16'h14c7, 21'h3d, 70, 1);
    slow <= 1'b0;
    burst(16'h2dcf, 21'h3fffc, 8, 0);
    burst(16'h1a8a, 21'h100, 8, 0);
    wrap_up;
  end
  // Watchdog well beyond the few microseconds the bursts need.
  initial begin
    #200000;
    num_errors = num_errors + 1;
    wrap_up;
  end
endmodule // testbench
